// File: adcfe_pkg.sv
// Operation
// - mode bit 0 selects low-power; reset comes up in high-resolution mode
// - input select 000 pair one, 001 pair two, 010 short, 011 both, 100 cm test
// - gain select code k gives amplifier gain 2**k, from 1 up to 64
// - full-scale range is 2.5 V at code 000, halving per higher gain code
// - amplifier chopping on by default, stopped when chopper enable written 0
// - amplifier chopper runs at master clock divided by 128
// - modulator input chopper runs at master clock divided by 512
// - internal digital filter is shut down while bitstream output is enabled
// - first-stage stream is about 90/10 percent ones at full scale, half at zero
// - filter path select 00 enables bitstream output, turning the three pins to outputs
// - modulator clock is master clock over 4, or over 8 in low-power mode
package adcfe_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0]  ADDR_CONFIG     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  // config fields
  localparam int          CFG_MODE_BIT    = 0;
  localparam int          CFG_ROUTE_LSB   = 1;
  localparam int          CFG_GAIN_LSB    = 4;
  localparam int          CFG_CHOPPER_ENABLE_BIT    = 7;
  localparam int          CFG_FILT_LSB    = 8;
  localparam logic [9:0]  CFG_RESET       = 10'h281;
  localparam logic [1:0]  FILT_MODULATOR  = 2'h0;
  // status fields
  localparam int          ST_MODOUT_BIT   = 0;
  localparam int          ST_FILTON_BIT   = 1;
  localparam int          ST_PINS_LSB     = 2;
  localparam int          ST_CHOPA_BIT    = 5;
  localparam int          ST_CHOPM_BIT    = 6;
  // ==========================================================
  // input routes and switch set (s7..s1)
  localparam logic [2:0]  ROUTE_PAIR_ONE  = 3'h0;
  localparam logic [2:0]  ROUTE_PAIR_TWO  = 3'h1;
  localparam logic [2:0]  ROUTE_SHORT     = 3'h2;
  localparam logic [2:0]  ROUTE_BOTH      = 3'h3;
  localparam logic [2:0]  ROUTE_CM_TEST   = 3'h4;
  localparam logic [2:0]  GAIN_MAX_CODE   = 3'h6;
  // ==========================================================
  // clock divisions
  localparam int          AMP_CHOPPER_ENABLE_DIV    = 128;
  localparam int          MOD_CHOPPER_ENABLE_DIV    = 512;
  localparam int          MCLK_DIV_HR     = 4;
  localparam int          MCLK_DIV_LP     = 8;
  localparam int          DIV_W           = $clog2(MOD_CHOPPER_ENABLE_DIV);
  localparam int          AMP_PHASE_BIT   = $clog2(AMP_CHOPPER_ENABLE_DIV) - 1;
  localparam int          MOD_PHASE_BIT   = $clog2(MOD_CHOPPER_ENABLE_DIV) - 1;
  localparam int          HR_PHASE_BIT    = $clog2(MCLK_DIV_HR) - 1;
  localparam int          LP_PHASE_BIT    = $clog2(MCLK_DIV_LP) - 1;
  // axi responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// File: adcfe_top.sv
`timescale 1ns/10ps
module adcfe_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [ADDR_W-1:0]             s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // analog modulator bits, same clock
  input  wire logic                          first_stage_bit,
  input  wire logic                          second_stage_bit,
  // front-end controls
  output logic                               low_power,
  output logic [6:0]                         route_switches,
  output logic [2:0]                         amp_gain_select,
  output logic [6:0]                         amp_gain,
  output logic                               amp_chopper_enable_clk,
  output logic                               mod_chopper_enable_clk,
  output logic                               digital_filter_en,
  // modulator pins, two-way
  input  wire logic                          mod_clk_in,
  output logic                               mod_clk_out,
  output logic                               mod_clk_oe,
  input  wire logic                          first_stage_bitstream_in,
  output logic                               first_stage_bitstream_out,
  output logic                               first_stage_bitstream_oe,
  input  wire logic                          second_stage_bitstream_in,
  output logic                               second_stage_bitstream_out,
  output logic                               second_stage_bitstream_oe
);
  import adcfe_pkg::*;

  // the register map needs byte offsets up to 4
  if (ADDR_W < 3) begin : g_addr_check
    $error("address too narrow for register map");
  end

  // ==========================================================
  // decode helpers
  // switch set per route; unused codes leave every switch open
  function automatic logic [6:0] route_decode(input logic [2:0] sel);
    logic [6:0] sw;
    sw = 7'h00;
    case (sel)
      ROUTE_PAIR_ONE: sw = 7'h11;
      ROUTE_PAIR_TWO: sw = 7'h22;
      ROUTE_SHORT:    sw = 7'h0c;
      ROUTE_BOTH:     sw = 7'h33;
      ROUTE_CM_TEST:  sw = 7'h60;
      default:        sw = 7'h00;
    endcase
    return sw;
  endfunction

  // gain is a power of two; code 111 is clamped to the top gain
  function automatic logic [6:0] gain_decode(input logic [2:0] code);
    logic [2:0] c;
    c = (code > GAIN_MAX_CODE) ? GAIN_MAX_CODE : code;
    return 7'h01 << c;
  endfunction

  // ==========================================================
  // register storage
  logic [9:0]        cfg;
  logic [DIV_W-1:0]  div_cnt;
  logic [2:0]        pin_s1, pin_s2, pin_s3;
  logic [2:0]        pin_val;
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_held;

  wire       cfg_low_power = ~cfg[CFG_MODE_BIT];
  wire [2:0] cfg_route     = cfg[CFG_ROUTE_LSB +: 3];
  wire [2:0] cfg_gain      = cfg[CFG_GAIN_LSB +: 3];
  wire       cfg_chopper_enable      = cfg[CFG_CHOPPER_ENABLE_BIT];
  wire       cfg_modout    = cfg[CFG_FILT_LSB +: 2] == FILT_MODULATOR;

  // ==========================================================
  // axi write path: address and data taken in either order
  wire aw_take   = s_axi_awvalid && s_axi_awready;
  wire w_take    = s_axi_wvalid && s_axi_wready;
  wire aw_have   = aw_held || aw_take;
  wire w_have    = w_held || w_take;
  wire wr_fire   = aw_have && w_have && !s_axi_bvalid;
  wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_cfg    = wr_fire && (wr_addr == ADDR_W'(ADDR_CONFIG));
  wire wr_status = wr_fire && (wr_addr == ADDR_W'(ADDR_STATUS));
  wire [9:0] cfg_wmask = {{2{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [9:0] next_cfg  = (cfg & ~cfg_wmask) | (wr_data[9:0] & cfg_wmask);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      cfg           <= CFG_RESET;
    end else begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_held       <= aw_have && !wr_fire;
      w_held        <= w_have && !wr_fire;
      s_axi_awready <= !(aw_have && !wr_fire) && !wr_fire && !s_axi_bvalid;
      s_axi_wready  <= !(w_have && !wr_fire) && !wr_fire && !s_axi_bvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_cfg || wr_status) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_cfg) begin
        cfg <= next_cfg;
      end
    end
  end

  // ==========================================================
  // axi read path: one cycle from address to data
  wire [31:0] status_word = {25'h0, mod_chopper_enable_clk, amp_chopper_enable_clk, pin_val,
                             digital_filter_en, mod_clk_oe};
  wire rd_cfg    = s_axi_araddr == ADDR_W'(ADDR_CONFIG);
  wire rd_status = s_axi_araddr == ADDR_W'(ADDR_STATUS);
  wire [31:0] rd_word = rd_cfg ? {22'h0, cfg} : (rd_status ? status_word : 32'h0);
  wire ar_take   = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (rd_cfg || rd_status) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !ar_take && !(s_axi_rvalid && !s_axi_rready);
    end
  end

  // ==========================================================
  // master clock divider; one counter serves every division so all
  // derived clocks keep a fixed phase to each other
  wire next_mclk = cfg_low_power ? div_cnt[LP_PHASE_BIT]
                                 : div_cnt[HR_PHASE_BIT];
  wire mclk_rise = next_mclk && !mod_clk_out;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_cnt      <= '0;
      amp_chopper_enable_clk <= 1'b0;
      mod_chopper_enable_clk <= 1'b0;
      mod_clk_out  <= 1'b0;
    end else begin
      div_cnt      <= div_cnt + 1'b1;
      // stopping the chopper parks the amp switches in one phase
      amp_chopper_enable_clk <= cfg_chopper_enable && div_cnt[AMP_PHASE_BIT];
      mod_chopper_enable_clk <= div_cnt[MOD_PHASE_BIT];
      mod_clk_out  <= next_mclk;
    end
  end

  // ==========================================================
  // bitstream output; bits change right after the clock rises, so the
  // far filter samples a settled value on the next rise
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      first_stage_bitstream_out  <= 1'b0;
      second_stage_bitstream_out <= 1'b0;
    end else if (mclk_rise) begin
      first_stage_bitstream_out  <= first_stage_bit;
      second_stage_bitstream_out <= second_stage_bit;
    end
  end

  // ==========================================================
  // front-end controls and pin directions
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      low_power                 <= 1'b0;
      route_switches            <= 7'h11;
      amp_gain_select           <= 3'h0;
      amp_gain                  <= 7'h01;
      digital_filter_en         <= 1'b1;
      mod_clk_oe                <= 1'b0;
      first_stage_bitstream_oe  <= 1'b0;
      second_stage_bitstream_oe <= 1'b0;
    end else begin
      low_power                 <= cfg_low_power;
      route_switches            <= route_decode(cfg_route);
      amp_gain_select           <= cfg_gain;
      amp_gain                  <= gain_decode(cfg_gain);
      digital_filter_en         <= !cfg_modout;
      mod_clk_oe                <= cfg_modout;
      first_stage_bitstream_oe  <= cfg_modout;
      second_stage_bitstream_oe <= cfg_modout;
    end
  end

  // ==========================================================
  // tied pin levels are only reported; three stages guard metastability,
  // and only the settled second and third stages are compared
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_s1  <= 3'h0;
      pin_s2  <= 3'h0;
      pin_s3  <= 3'h0;
      pin_val <= 3'h0;
    end else begin
      pin_s1  <= {second_stage_bitstream_in, first_stage_bitstream_in, mod_clk_in};
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      // per bit: take the level where stages agree, keep the old one otherwise
      pin_val <= (pin_s2 & pin_s3) | (pin_val & (pin_s2 | pin_s3));
    end
  end
endmodule

// File: adcfe_monitor.sv
`timescale 1ns/10ps
// ==========================================
// pin-level checker for the front-end control block
module adcfe_monitor (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       low_power,
  input wire logic [6:0] route_switches,
  input wire logic [2:0] amp_gain_select,
  input wire logic [6:0] amp_gain,
  input wire logic       amp_chopper_enable_clk,
  input wire logic       mod_chopper_enable_clk,
  input wire logic       digital_filter_en,
  input wire logic       mod_clk_out,
  input wire logic       mod_clk_oe,
  input wire logic       first_stage_bitstream_out,
  input wire logic       first_stage_bitstream_oe,
  input wire logic       second_stage_bitstream_out,
  input wire logic       second_stage_bitstream_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // reset state is watched while reset is held, so this one is never disabled
  reset_state_a: assert property (disable iff (1'b0) !nrst |-> !low_power && !mod_clk_oe)
    else $error("wrong state during reset");
  route_legal_a: assert property (route_switches inside {7'h11, 7'h22, 7'h0c, 7'h33, 7'h60, 7'h00})
    else $error("illegal switch set");
  gain_pow_a: assert property (amp_gain == (amp_gain_select == 3'h7 ? 7'h40 : 7'h01 << amp_gain_select))
    else $error("gain not a power of two of the code");
  filter_off_a: assert property (mod_clk_oe != digital_filter_en)
    else $error("filter running with bitstream out");
  pins_dir_a: assert property (first_stage_bitstream_oe == mod_clk_oe && second_stage_bitstream_oe == mod_clk_oe)
    else $error("modulator pins disagree on direction");
  amp_chopper_enable_a: assert property ($rose(amp_chopper_enable_clk) |-> ##64 !amp_chopper_enable_clk)
    else $error("amp chopper high phase wrong");
  mod_chopper_enable_a: assert property ($rose(mod_chopper_enable_clk) |-> ##256 $fell(mod_chopper_enable_clk))
    else $error("modulator chopper high phase wrong");
  // a mode switch inside a period may stretch it, so the mode bit excuses each cycle
  mclk_fast_a: assert property ($rose(mod_clk_out) && !low_power |=> (mod_clk_out || low_power) ##1 (!mod_clk_out || low_power))
    else $error("modulator clock not over 4");
  mclk_slow_a: assert property ($rose(mod_clk_out) && low_power |=> (mod_clk_out || !low_power) [*3] ##1 (!mod_clk_out || !low_power))
    else $error("modulator clock not over 8");
  data_edge_a: assert property ($changed(first_stage_bitstream_out) |-> $rose(mod_clk_out))
    else $error("bitstream moved off the clock rise");
  second_edge_a: assert property ($changed(second_stage_bitstream_out) |-> $rose(mod_clk_out))
    else $error("second bitstream moved off the clock rise");
  cover property ($rose(mod_clk_oe));
  cover property (low_power && $rose(mod_clk_out));
  cover property ($fell(amp_chopper_enable_clk));
endmodule

// File: adcfe_filter_model.sv
`timescale 1ns/10ps
// ==========================================
// far-side merge filter fed by the modulator pins
module adcfe_filter_model (
  input  wire logic        mod_clk,
  input  wire logic        first_bit,
  input  wire logic        second_bit,
  output logic signed [7:0] merged
);
  logic [4:0] a = 5'h00;
  logic [2:0] b = 3'h0;
  // newest sample lands in bit 0 on every modulator clock rise
  always @(posedge mod_clk) begin
    a <= {a[3:0], first_bit};
    b <= {b[1:0], second_bit};
  end
  // bits count as unsigned 0 or 1; 8 signed bits hold the range -24..+25
  assign merged = 8'(3 * int'(a[2]) - 6 * int'(a[3]) + 4 * int'(a[4])
                  + 9 * (int'(b[0]) - 2 * int'(b[1]) + int'(b[2])));
endmodule

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import adcfe_pkg::*;
  // ==========================================
  // stimulus and observed pins
  logic        clk_sys = 1'b0, nrst = 1'b1, first_stage_bit = 1'b0, second_stage_bit = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, low_power, amp_chopper_enable_clk;
  logic        mod_chopper_enable_clk, digital_filter_en, mod_clk_out, mod_clk_oe;
  logic        first_stage_bitstream_out, first_stage_bitstream_oe;
  logic        second_stage_bitstream_out, second_stage_bitstream_oe;
  logic [6:0]  route_switches, amp_gain;
  logic [2:0]  amp_gain_select;
  logic signed [7:0] merged;
  logic [6:0]  rtab [5] = '{7'h11, 7'h22, 7'h0c, 7'h33, 7'h60};
  int          n_mismatch = 0, checks = 0, p, hi;
  // pins are tied low by the board whenever the block does not drive them
  wire mod_clk_in = mod_clk_oe ? mod_clk_out : 1'b0;
  // data pins settle a little after the modulator clock rises, so the far
  // filter sees the previous bit on that rise without a race
  wire #10 first_stage_bitstream_in = first_stage_bitstream_oe ? first_stage_bitstream_out : 1'b0;
  wire #10 second_stage_bitstream_in = second_stage_bitstream_oe ? second_stage_bitstream_out : 1'b0;
  adcfe_top i_adcfe_top (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .first_stage_bit, .second_stage_bit, .low_power,
    .route_switches, .amp_gain_select, .amp_gain, .amp_chopper_enable_clk, .mod_chopper_enable_clk,
    .digital_filter_en, .mod_clk_in, .mod_clk_out, .mod_clk_oe, .first_stage_bitstream_in,
    .first_stage_bitstream_out, .first_stage_bitstream_oe, .second_stage_bitstream_in,
    .second_stage_bitstream_out, .second_stage_bitstream_oe);
  adcfe_filter_model i_adcfe_filter_model (.mod_clk(mod_clk_in),
    .first_bit(first_stage_bitstream_in), .second_bit(second_stage_bitstream_in), .merged);
  // 10 MHz system clock
  initial forever #50 clk_sys = ~clk_sys;
  // ==========================================
  // bus tasks; each starts just after a rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    // controls follow the register a cycle later
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // cycles between two rises of a square wave; the watchdog catches a stopped one
  task automatic period(input int sel);
    logic pv, v;
    int k;
    k = 0;
    p = 0;
    pv = 1'b1;
    while (k < 2) begin
      @(posedge clk_sys);
      v = sel == 0 ? mod_clk_out : sel == 1 ? amp_chopper_enable_clk : mod_chopper_enable_clk;
      if (k == 1) p++;
      if (v && !pv) k++;
      pv = v;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================
  // test sequence
  initial begin
    nrst <= 1'b0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    axi_rd(ADDR_CONFIG);
    chk(rd, 32'h281, "config reset");
    chk(low_power, 1'b0, "mode at reset");
    chk(mod_clk_oe, 1'b0, "pins input at reset");
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      axi_wr(ADDR_CONFIG, 32'h281 | (i << 1), 4'hf);
      chk(route_switches, rtab[i], "route");
    end
    for (int k = 0; k < 7; k++) begin
      axi_wr(ADDR_CONFIG, 32'h281 | (k << 4), 4'hf);
      chk(amp_gain, 32'h1 << k, "gain");
      chk(amp_gain_select, k, "gain code");
    end
    // unused route code opens every switch, gain code 7 clamps to the top gain
    axi_wr(ADDR_CONFIG, 32'h2fb, 4'hf);
    chk(route_switches, 7'h00, "unused route");
    chk(amp_gain, 7'h40, "gain clamp");
    $display("test route and gain done");
    period(1);
    chk(p, 128, "amp chopper_enable period");
    period(2);
    chk(p, 512, "mod chopper_enable period");
    axi_wr(ADDR_CONFIG, 32'h201, 4'hf);
    hi = 0;
    repeat (300) begin
      @(posedge clk_sys);
      hi += amp_chopper_enable_clk;
    end
    chk(hi, 0, "chopper stopped");
    $display("test chopper done");
    axi_wr(ADDR_CONFIG, 32'h081, 4'hf);
    chk(mod_clk_oe, 1'b1, "pins output");
    chk(digital_filter_en, 1'b0, "filter off");
    axi_rd(ADDR_STATUS);
    chk(rd & 32'hffff_ff83, 32'h1, "status bitstream mode");
    period(0);
    chk(p, 4, "mod clock fast");
    first_stage_bit <= 1'b1;
    repeat (80) @(posedge clk_sys);
    chk(merged, 32'h1, "merged stream");
    second_stage_bit <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk(second_stage_bitstream_out, 1'b1, "second stream out");
    chk(merged, 32'h1, "merged both streams");
    axi_wr(ADDR_CONFIG, 32'h080, 4'hf);
    chk(low_power, 1'b1, "low power");
    period(0);
    chk(p, 8, "mod clock slow");
    $display("test bitstream done");
    axi_wr(ADDR_CONFIG, 32'h300, 4'h2);
    axi_rd(ADDR_CONFIG);
    chk(rd, 32'h380, "upper byte only");
    chk(digital_filter_en, 1'b1, "filter back on");
    axi_wr(8'h10, 32'h0, 4'hf);
    chk(rsp, RESP_SLVERR, "unmapped write");
    axi_rd(8'h10);
    chk(rsp, RESP_SLVERR, "unmapped read");
    chk(rd, 32'h0, "unmapped data");
    axi_wr(ADDR_STATUS, 32'hffff_ffff, 4'hf);
    chk(rsp, RESP_OKAY, "status write");
    axi_rd(ADDR_CONFIG);
    chk(rd, 32'h380, "status write ignored");
    axi_rd(ADDR_STATUS);
    chk(rd & 32'hffff_ff9f, 32'h2, "status filter mode");
    $display("test bus done");
    end_sim();
  end
  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    #2000000;
    n_mismatch++;
    end_sim();
  end
endmodule
bind adcfe_top adcfe_monitor i_adcfe_monitor (.clk_sys, .nrst, .low_power, .route_switches,
  .amp_gain_select, .amp_gain, .amp_chopper_enable_clk, .mod_chopper_enable_clk, .digital_filter_en, .mod_clk_out,
  .mod_clk_oe, .first_stage_bitstream_out, .first_stage_bitstream_oe, .second_stage_bitstream_out,
  .second_stage_bitstream_oe);
